// >>> verilog/ivpm_pkg.sv
// constants and carrier types for the interrupt vector and priority map
// assumes one system clock and an active-low asynchronous reset
// Contract
// - there are 24 request lines, line n vectors at upper 16'hfffa-2n and lower one above.
// - each line takes a two-bit level from its own field of the level settings.
// - among pending lines of the same best level the lowest number is served first.
// - external channels 4 and 5 drive lines 0 and 1, 2 and 6 share line 2, 3 and 7 line 3.
// - composite timer 0 lower/upper use lines 5/6, timer 1 upper line 14, lower line 22.
// - a read of an unassigned peripheral address returns an undefined value.
package ivpm_pkg;

  // ----------------------------------------
  // line map
  // ----------------------------------------
  localparam int unsigned NUM_LINES = 24;
  localparam int unsigned LEVEL_W = 2;
  localparam int unsigned LINE_IDX_W = 5;
  localparam logic [15:0] VEC_BASE_UPPER = 16'hfffa;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [1:0] LEVEL_RESET = 2'h3;
  localparam logic [1:0] LEVEL_DISABLED = 2'h3;

  localparam int unsigned LINE_EXT4 = 0;
  localparam int unsigned LINE_EXT5 = 1;
  localparam int unsigned LINE_EXT2_6 = 2;
  localparam int unsigned LINE_EXT3_7 = 3;
  localparam int unsigned LINE_TMR0_LO = 5;
  localparam int unsigned LINE_TMR0_HI = 6;
  localparam int unsigned LINE_UART_RX = 7;
  localparam int unsigned LINE_UART_TX = 8;
  localparam int unsigned LINE_TMR1_HI = 14;
  localparam int unsigned LINE_ADC = 18;
  localparam int unsigned LINE_TBT = 19;
  localparam int unsigned LINE_WPRE = 20;
  localparam int unsigned LINE_TMR1_LO = 22;
  localparam int unsigned LINE_FLASH = 23;

  // lines with a source in each variant
  localparam logic [23:0] USED_FULL = 24'hdc41ef;
  localparam logic [23:0] USED_SMALL = 24'h9c0065;
  localparam logic [23:0] USED_NO_UART = 24'hdc406f;

  typedef enum logic [1:0] {ivpm_var_full, ivpm_var_small, ivpm_var_no_uart} ivpm_variant_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ext;
    logic tmr0_lo;
    logic tmr0_hi;
    logic tmr1_lo;
    logic tmr1_hi;
    logic uart_rx;
    logic uart_tx;
    logic adc;
    logic tbt;
    logic wpre;
    logic flash;
  } ivpm_src_s;

  typedef struct packed {
    logic valid;
    logic [4:0] line;
    logic [1:0] level;
    logic [15:0] vec_upper;
    logic [15:0] vec_lower;
  } ivpm_req_s;

endpackage

// >>> verilog/ivpm_map.sv
// request line mapping, level lookup and same-level priority resolve
// assumes sources are synchronous to clk; the core accepts a request
// when its level is numerically below its current mask level
`timescale 1ns/10ps
module ivpm_map #(
  parameter ivpm_pkg::ivpm_variant_e VARIANT = ivpm_pkg::ivpm_var_full
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ivpm_pkg::ivpm_src_s src,
  input wire logic [47:0] level_fields,
  input wire logic [1:0] cpu_mask_level,
  output ivpm_pkg::ivpm_req_s req,
  output logic [23:0] pending_lines,
  output logic [7:0] unmapped_read_data
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ivpm_pkg::ivpm_req_s req;
    logic [23:0] pending;
    logic [7:0] noise;
  } ivpm_state_s;

  ivpm_state_s state_ff;
  ivpm_state_s nxt_state;

  initial
  begin
    if (ivpm_pkg::NUM_LINES * ivpm_pkg::LEVEL_W != 48)
    begin
      $error("level field width mismatch");
    end
  end

  function automatic logic [23:0] used_mask(input ivpm_pkg::ivpm_variant_e v);
    unique case (v)
      ivpm_pkg::ivpm_var_full: used_mask = ivpm_pkg::USED_FULL;
      ivpm_pkg::ivpm_var_small: used_mask = ivpm_pkg::USED_SMALL;
      ivpm_pkg::ivpm_var_no_uart: used_mask = ivpm_pkg::USED_NO_UART;
      default: used_mask = 24'h000000;
    endcase
  endfunction

  function automatic logic [15:0] vec_upper_of(input logic [4:0] line);
    vec_upper_of = ivpm_pkg::VEC_BASE_UPPER - 16'(line) * ivpm_pkg::VEC_STEP;
  endfunction

  // ----------------------------------------
  // source to line mapping
  // ----------------------------------------
  logic [23:0] raw_lines;
  logic [23:0] used;

  always_comb
  begin
    raw_lines = 24'h000000;
    raw_lines[ivpm_pkg::LINE_EXT4] = src.ext[4];
    raw_lines[ivpm_pkg::LINE_EXT5] = src.ext[5];
    raw_lines[ivpm_pkg::LINE_EXT2_6] = src.ext[2] | src.ext[6];
    raw_lines[ivpm_pkg::LINE_EXT3_7] = src.ext[3] | src.ext[7];
    raw_lines[ivpm_pkg::LINE_TMR0_LO] = src.tmr0_lo;
    raw_lines[ivpm_pkg::LINE_TMR0_HI] = src.tmr0_hi;
    raw_lines[ivpm_pkg::LINE_TMR1_HI] = src.tmr1_hi;
    raw_lines[ivpm_pkg::LINE_TMR1_LO] = src.tmr1_lo;
    raw_lines[ivpm_pkg::LINE_UART_RX] = src.uart_rx;
    raw_lines[ivpm_pkg::LINE_UART_TX] = src.uart_tx;
    raw_lines[ivpm_pkg::LINE_ADC] = src.adc;
    raw_lines[ivpm_pkg::LINE_TBT] = src.tbt;
    raw_lines[ivpm_pkg::LINE_WPRE] = src.wpre;
    raw_lines[ivpm_pkg::LINE_FLASH] = src.flash;
    used = used_mask(VARIANT);
  end

  // ----------------------------------------
  // resolve: best level, then lowest line
  // ----------------------------------------
  logic [23:0] live;
  logic found;
  logic [4:0] win_line;
  logic [1:0] win_level;
  logic [1:0] lvl;

  always_comb
  begin
    live = raw_lines & used;
    found = 1'b0;
    win_line = 5'h00;
    win_level = ivpm_pkg::LEVEL_DISABLED;
    lvl = 2'h0;
    for (int i = 0; i < 24; i++)
    begin
      lvl = level_fields[2 * i +: 2];
      // strict less keeps the lower line on a tie
      if (live[i] && (!found || lvl < win_level))
      begin
        found = 1'b1;
        win_line = 5'(i);
        win_level = lvl;
      end
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.pending = live;
    nxt_state.req.valid = found && (win_level < cpu_mask_level);
    nxt_state.req.line = win_line;
    nxt_state.req.level = win_level;
    nxt_state.req.vec_upper = vec_upper_of(win_line);
    nxt_state.req.vec_lower = vec_upper_of(win_line) + 16'h0001;
    // free-running value; unassigned reads need not be stable
    nxt_state.noise = {state_ff.noise[6:0], state_ff.noise[7] ^ state_ff.noise[5]
      ^ state_ff.noise[4] ^ state_ff.noise[3]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '{req: '{valid: 1'b0, line: 5'h00, level: ivpm_pkg::LEVEL_RESET,
        vec_upper: ivpm_pkg::VEC_BASE_UPPER, vec_lower: 16'hfffb},
        pending: 24'h000000, noise: 8'ha5};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign req = state_ff.req;
  assign pending_lines = state_ff.pending;
  assign unmapped_read_data = state_ff.noise;

endmodule

// >>> testbench/ivpm_cpu_model.sv
// core-side model: sets the mask level and fetches the offered vector
// assumes the request record of ivpm_map
`timescale 1ns/10ps
module ivpm_cpu_model (
  input wire logic [1:0] mask_in,
  input wire ivpm_pkg::ivpm_req_s req,
  output logic [1:0] cpu_mask_level,
  output logic [15:0] fetch_vec
);
  // only reads vectors, never writes an unassigned address
  assign cpu_mask_level = mask_in;
  assign fetch_vec = req.valid ? req.vec_upper : 16'h0;
endmodule

// >>> testbench/ivpm_map_properties.sv
// checker for the vector and priority map
// assumes binding to every ivpm_map
`timescale 1ns/10ps
module ivpm_map_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire ivpm_pkg::ivpm_src_s src,
  input wire logic [47:0] level_fields,
  input wire logic [1:0] cpu_mask_level,
  input wire ivpm_pkg::ivpm_req_s req,
  input wire logic [23:0] pending_lines,
  input wire logic [7:0] unmapped_read_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_vec_addr: assert property (
    req.valid |-> req.vec_upper + 16'({req.line, 1'b0}) == 16'hfffa) else $error("bad vector");
  chk_level_field: assert property (
    req.valid |-> req.level == 2'($past(level_fields) >> {req.line, 1'b0})) else $error("level");
  chk_mask_gate: assert property (req.valid |-> req.level < $past(cpu_mask_level))
    else $error("offered above mask");
  chk_line_zero: assert property (
    req.valid && pending_lines[0] && req.level == $past(level_fields[1:0]) |-> req.line == 5'h0)
    else $error("priority order");
  chk_shared_ext: assert property (src.ext[6] |=> pending_lines[2]) else $error("shared line");
  chk_timer_map: assert property (src.tmr0_lo |=> pending_lines[5]) else $error("timer line");
  chk_noise_moves: assert property ($past(rst_n) |-> !$stable(unmapped_read_data))
    else $error("unassigned read stable");
  chk_unused_dark: assert property ((pending_lines & ~ivpm_pkg::USED_FULL) == 24'h0)
    else $error("unused line asserted");
  cover property (req.valid && req.line == 5'h16);
  cover property (req.valid && req.line == 5'h0);
  cover property (req.valid && req.line == 5'h5);
endmodule
bind ivpm_map ivpm_map_chk ivpm_map_chk_i (.clk(clk), .rst_n(rst_n), .src(src),
  .level_fields(level_fields), .cpu_mask_level(cpu_mask_level), .req(req),
  .pending_lines(pending_lines), .unmapped_read_data(unmapped_read_data));

// >>> testbench/interrupt_vector_priority_map_test.sv
// self-checking bench for the vector and priority map
// assumes the full variant with the core model at the far side
`timescale 1ns/10ps
module interrupt_vector_priority_map_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ivpm_pkg::ivpm_src_s src = '0;
  logic [47:0] lv = '0;
  logic [1:0] mask_in = 2'h3;
  logic [1:0] cpu_mask_level;
  logic [15:0] fetch_vec;
  ivpm_pkg::ivpm_req_s req;
  logic [23:0] pend;
  logic [7:0] noise;
  int miscompares = 0;
  int num_checks = 0;
  // line per source bit, 31 for no line
  int ln[18] = '{23, 20, 19, 18, 8, 7, 14, 22, 6, 5, 31, 31, 2, 3, 0, 1, 2, 3};
  ivpm_map ivpm_map_i (.clk(clk), .rst_n(rst_n), .src(src), .level_fields(lv),
    .cpu_mask_level(cpu_mask_level), .req(req), .pending_lines(pend), .unmapped_read_data(noise));
  ivpm_cpu_model ivpm_cpu_model_i (.mask_in(mask_in), .req(req),
    .cpu_mask_level(cpu_mask_level), .fetch_vec(fetch_vec));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(logic [71:0] got, logic [71:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(ivpm_pkg::ivpm_src_s s, logic [47:0] l, logic [1:0] m, logic v, int n);
    @(posedge clk);
    src <= s;
    lv <= l;
    mask_in <= m;
    @(posedge clk);
    #1;
    chk(req.valid, v);
    if (v)
      chk({req.line, req.level, fetch_vec, req.vec_lower},
        {5'(n), 2'(l >> 2 * n), 16'hfffa - 16'(2 * n), 16'hfffb - 16'(2 * n)});
  endtask
  task automatic t_reset();
    repeat (8) @(posedge clk);
    chk({req, pend, noise}, {1'b0, 5'h0, 2'h3, 16'hfffa, 16'hfffb, 24'h0, 8'ha5});
    rst_n <= 1'b1;
  endtask
  task automatic t_map();
    for (int i = 0; i < 18; i++)
    begin
      run(18'h1 << i, 48'h0, 2'h3, ln[i] < 31, ln[i]);
      chk(pend, ln[i] < 31 ? 24'h1 << ln[i] : 24'h0);
    end
  endtask
  task automatic t_prio();
    run(18'h3ffff, 48'haaaaaaaaaaaa, 2'h3, 1'b1, 0);
    run(18'h00280, 48'h9aaaaaaaaaaa, 2'h3, 1'b1, 22);
    run(18'h00280, 48'ha9aaaaaaa6aa, 2'h3, 1'b1, 5);
    run(18'h00280, 48'ha9aaaaaaa6aa, 2'h1, 1'b0, 0);
    run(18'h00280, 48'ha9aaaaaaa6aa, 2'h2, 1'b1, 5);
    run(18'h3ffff, 48'hffffffffffff, 2'h3, 1'b0, 0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_map();
    t_prio();
    end_sim();
  end
endmodule
